// *** src/bsc_pkg.sv ***
package bsc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] RX_CTRL_OFS = 8'h28;
	localparam logic [7:0] SWITCH_MATRIX_CTRL_OFS = 8'h41;
	localparam logic [7:0] LOAD_AND_GUARD_CTRL_OFS = 8'h42;

	// ****************************************
	// Receive control fields
	// ****************************************
	localparam int RX_PGA_RATE_BIT = 0;
	localparam int RX_INAMP_CHOP_BIT = 1;
	localparam int RX_I_PHASE_BIT = 2;
	localparam int RX_Q_PHASE_BIT = 3;
	localparam logic [7:0] RX_CTRL_MASK = 8'h0F;
	localparam logic [7:0] RX_CTRL_RST = 8'h00;

	// ****************************************
	// Switch matrix fields
	// ****************************************
	localparam int SM_CAL_PORT_BIT = 0;
	localparam int SM_MATRIX_BIT = 1;
	localparam int SM_CAL_EXCL_BIT = 2;
	localparam int SM_SELFTEST_BIT = 5;
	localparam int SM_CAL_SEL_LSB = 6;
	localparam logic [7:0] SM_CTRL_MASK = 8'hE7;
	localparam logic [7:0] SM_CTRL_RST = 8'h00;

	// ****************************************
	// Load and guard fields
	// ****************************************
	localparam int LG_CAP_COMP_BIT = 0;
	localparam int LG_GUARD_BIT = 1;
	localparam int LG_SKIN_BIT = 5;
	localparam int LG_SKIN_SEL_LSB = 6;
	localparam logic [7:0] LG_CTRL_MASK = 8'hE3;
	localparam logic [7:0] LG_CTRL_RST = 8'h00;

	// ****************************************
	// Chopping dividers, in converter clock ticks per half period
	// ****************************************
	localparam int CHOP_CNT_W = 3;
	localparam logic [2:0] INAMP_CHOP_HALF = 3'h1;
	localparam logic [2:0] PGA_CHOP_HALF_DIV8 = 3'h4;
	localparam logic [2:0] PGA_CHOP_HALF_DIV4 = 3'h2;

endpackage

// *** src/bsc_chop_div.sv ***
`timescale 1ns/1ns
`default_nettype none
module bsc_chop_div #(
	parameter int CNT_W = 3
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_tick,
	input wire logic i_en,
	input wire logic [CNT_W-1:0] i_half,
	// Chopper phase
	output logic o_chop
);

	logic [CNT_W-1:0] cnt_q;

	initial begin
		if (CNT_W < 2) begin
			$error("bsc_chop_div: CNT_W must be at least 2");
		end
	end

	// ****************************************
	// Toggle the phase after i_half converter ticks.
	// ****************************************
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
			o_chop <= 1'b0;
		end else if (!i_en) begin
			cnt_q <= '0;
			o_chop <= 1'b0;
		end else if (i_tick) begin
			if (cnt_q + 1'b1 >= i_half) begin
				cnt_q <= '0;
				o_chop <= ~o_chop;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// *** src/bsc_switch_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none

module bsc_switch_ctrl
	import bsc_pkg::*;
#(
	parameter int HALF_W = CHOP_CNT_W
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// Timing references from the synthesizer
	input wire logic i_conv_tick,
	input wire logic i_stim_inphase,
	input wire logic i_stim_quad,
	// Demodulator and chopper clocks
	output logic o_i_demod_clk,
	output logic o_q_demod_clk,
	output logic o_inamp_chop,
	output logic o_pga_chop,
	// Switch matrix controls
	output logic o_electrode_pins_on,
	output logic [3:0] o_cal_pin_on,
	// Load, guard and compensation controls
	output logic [3:0] o_selftest_load_sel,
	output logic [3:0] o_skin_load_sel,
	output logic o_guard_drive_on,
	output logic o_input_cap_comp_on
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	initial begin
		if (HALF_W < CHOP_CNT_W) begin
			$error("bsc_switch_ctrl: HALF_W too narrow for the chop dividers");
		end
	end

	// ****************************************
	// Decoding helpers
	// ****************************************

	// Turns a two-bit value select into one switch enable, gated by the load enable.
	function automatic logic [3:0] load_onehot(input logic en, input logic [1:0] sel);
		logic [3:0] r;
		r = 4'h0;
		if (en) begin
			r[sel] = 1'b1;
		end
		return r;
	endfunction

	// ****************************************
	// Register storage
	// ****************************************
	logic [DATA_W-1:0] rx_ctrl_q;
	logic [DATA_W-1:0] sm_ctrl_q;
	logic [DATA_W-1:0] lg_ctrl_q;

	logic wr_rx;
	logic wr_sm;
	logic wr_lg;

	assign wr_rx = i_wr && (i_addr == RX_CTRL_OFS);
	assign wr_sm = i_wr && (i_addr == SWITCH_MATRIX_CTRL_OFS);
	assign wr_lg = i_wr && (i_addr == LOAD_AND_GUARD_CTRL_OFS);

	// Reserved positions are masked off so they never store a one.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_ctrl_q <= RX_CTRL_RST;
		end else if (wr_rx) begin
			rx_ctrl_q <= i_wdata & RX_CTRL_MASK;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sm_ctrl_q <= SM_CTRL_RST;
		end else if (wr_sm) begin
			sm_ctrl_q <= i_wdata & SM_CTRL_MASK;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			lg_ctrl_q <= LG_CTRL_RST;
		end else if (wr_lg) begin
			lg_ctrl_q <= i_wdata & LG_CTRL_MASK;
		end
	end

	// ****************************************
	// Read port
	// ****************************************

	// Data stand in the cycle after the read strobe only; unmapped offsets read zero.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			unique case (i_addr)
				RX_CTRL_OFS: begin
					o_rdata <= rx_ctrl_q;
				end
				SWITCH_MATRIX_CTRL_OFS: begin
					o_rdata <= sm_ctrl_q;
				end
				LOAD_AND_GUARD_CTRL_OFS: begin
					o_rdata <= lg_ctrl_q;
				end
				default: begin
					o_rdata <= '0;
				end
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// ****************************************
	// Field views
	// ****************************************
	logic q_demod_phase_sel;
	logic i_demod_phase_sel;
	logic inamp_chop_on;
	logic pga_chop_rate_sel;
	logic switch_matrix_on;
	logic cal_port_on;
	logic cal_pins_exclusive;
	logic selftest_load_on;
	logic [1:0] cal_load_value_sel;
	logic skin_load_on;
	logic [1:0] skin_load_value_sel;
	logic guard_drive_on;
	logic input_cap_comp_on;

	assign q_demod_phase_sel = rx_ctrl_q[RX_Q_PHASE_BIT];
	assign i_demod_phase_sel = rx_ctrl_q[RX_I_PHASE_BIT];
	assign inamp_chop_on = rx_ctrl_q[RX_INAMP_CHOP_BIT];
	assign pga_chop_rate_sel = rx_ctrl_q[RX_PGA_RATE_BIT];
	assign switch_matrix_on = sm_ctrl_q[SM_MATRIX_BIT];
	assign cal_port_on = sm_ctrl_q[SM_CAL_PORT_BIT];
	assign cal_pins_exclusive = sm_ctrl_q[SM_CAL_EXCL_BIT];
	assign selftest_load_on = sm_ctrl_q[SM_SELFTEST_BIT];
	assign cal_load_value_sel = sm_ctrl_q[SM_CAL_SEL_LSB +: 2];
	assign skin_load_on = lg_ctrl_q[LG_SKIN_BIT];
	assign skin_load_value_sel = lg_ctrl_q[LG_SKIN_SEL_LSB +: 2];
	assign guard_drive_on = lg_ctrl_q[LG_GUARD_BIT];
	assign input_cap_comp_on = lg_ctrl_q[LG_CAP_COMP_BIT];

	// ****************************************
	// Demodulator clock phase
	// ****************************************

	// The references come from synchronous synthesizer logic, so no synchroniser.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_i_demod_clk <= 1'b0;
			o_q_demod_clk <= 1'b0;
		end else begin
			o_i_demod_clk <= i_demod_phase_sel ? i_stim_quad : i_stim_inphase;
			o_q_demod_clk <= q_demod_phase_sel ? i_stim_inphase : i_stim_quad;
		end
	end

	// ****************************************
	// Chopping clocks
	// ****************************************
	logic [HALF_W-1:0] pga_half;
	logic [HALF_W-1:0] inamp_half;

	assign inamp_half = HALF_W'(INAMP_CHOP_HALF);
	assign pga_half = pga_chop_rate_sel ? HALF_W'(PGA_CHOP_HALF_DIV4) : HALF_W'(PGA_CHOP_HALF_DIV8);

	// One converter tick per half period gives converter clock divided by two.
	bsc_chop_div #(
		.CNT_W(HALF_W)
	) u_inamp_chop (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_tick(i_conv_tick),
		.i_en(inamp_chop_on),
		.i_half(inamp_half),
		.o_chop(o_inamp_chop)
	);

	// The PGA and anti-alias filter chop continuously at the selected rate.
	bsc_chop_div #(
		.CNT_W(HALF_W)
	) u_pga_chop (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_tick(i_conv_tick),
		.i_en(1'b1),
		.i_half(pga_half),
		.o_chop(o_pga_chop)
	);

	// ****************************************
	// Switch matrix decode
	// ****************************************
	logic cal_conn;
	logic elec_conn;

	always_comb begin
		cal_conn = 1'b0;
		elec_conn = 1'b0;
		if (switch_matrix_on) begin
			elec_conn = !(cal_port_on && cal_pins_exclusive);
			cal_conn = cal_port_on;
		end
	end

	// Pin enables, index 0 to 3: pos drive, pos sense, neg sense, neg drive.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_electrode_pins_on <= 1'b0;
			o_cal_pin_on <= 4'h0;
		end else begin
			o_electrode_pins_on <= elec_conn;
			o_cal_pin_on <= {4{cal_conn}};
		end
	end

	// ****************************************
	// Internal loads, guard and compensation
	// ****************************************

	// Each select bit closes one resistor across both drive/sense node pairs.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_selftest_load_sel <= 4'h0;
			o_skin_load_sel <= 4'h0;
		end else begin
			o_selftest_load_sel <= load_onehot(selftest_load_on, cal_load_value_sel);
			o_skin_load_sel <= load_onehot(skin_load_on, skin_load_value_sel);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_guard_drive_on <= 1'b0;
			o_input_cap_comp_on <= 1'b0;
		end else begin
			o_guard_drive_on <= guard_drive_on;
			o_input_cap_comp_on <= input_cap_comp_on;
		end
	end

endmodule
`default_nettype wire

// *** test/bsc_switch_ctrl_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module bsc_switch_ctrl_props
	import bsc_pkg::*;
(
	// Clock, reset and register port
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	// Switch, load and guard controls
	input wire logic o_electrode_pins_on,
	input wire logic [3:0] o_cal_pin_on,
	input wire logic [3:0] o_selftest_load_sel,
	input wire logic [3:0] o_skin_load_sel,
	input wire logic o_guard_drive_on
);
	wire sm_wr = i_wr && i_addr == SWITCH_MATRIX_CTRL_OFS;
	wire lg_wr = i_wr && i_addr == LOAD_AND_GUARD_CTRL_OFS;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_sm;
		sm_wr ##1 !sm_wr;
	endsequence
	sequence s_lg;
		lg_wr ##1 !lg_wr;
	endsequence
	chk_matrix_off: assert property (s_sm |=> $past(i_wdata[1], 2) || o_cal_pin_on == 4'h0 && !o_electrode_pins_on)
		else $error("pins on with matrix off");
	chk_cal_only: assert property (s_sm |=> $past(i_wdata[2:0], 2) != 3'h7 || o_cal_pin_on == 4'hF && !o_electrode_pins_on)
		else $error("exclusive calibration wrong");
	chk_cal_and_pins: assert property (s_sm |=> $past(i_wdata[2:0], 2) != 3'h3 || o_cal_pin_on == 4'hF && o_electrode_pins_on)
		else $error("shared calibration wrong");
	chk_selftest_sel: assert property (s_sm |=> o_selftest_load_sel == ($past(i_wdata[5], 2) ? 4'h1 << $past(i_wdata[7:6], 2) : 4'h0))
		else $error("self-test load select wrong");
	chk_skin_sel: assert property (s_lg |=> o_skin_load_sel == ($past(i_wdata[5], 2) ? 4'h1 << $past(i_wdata[7:6], 2) : 4'h0))
		else $error("skin load select wrong");
	chk_guard_follow: assert property (s_lg |=> o_guard_drive_on == $past(i_wdata[1], 2))
		else $error("guard drive wrong");
	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_rsvd_zero: assert property ($past(i_rd) && $past(i_addr) == SWITCH_MATRIX_CTRL_OFS |-> (o_rdata & ~SM_CTRL_MASK) == 8'h00)
		else $error("reserved bits read nonzero");
endmodule
bind bsc_switch_ctrl bsc_switch_ctrl_props i_bsc_switch_ctrl_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_electrode_pins_on(o_electrode_pins_on), .o_cal_pin_on(o_cal_pin_on),
	.o_selftest_load_sel(o_selftest_load_sel), .o_skin_load_sel(o_skin_load_sel),
	.o_guard_drive_on(o_guard_drive_on));
`default_nettype wire

// *** test/tb_bsc_switch_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_bsc_switch_ctrl
	import bsc_pkg::*;
;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
	logic i_conv_tick = 1'b0, i_stim_inphase = 1'b0, i_stim_quad = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, sm, lg;
	logic o_i_demod_clk, o_q_demod_clk, o_inamp_chop, o_pga_chop, o_electrode_pins_on;
	logic o_guard_drive_on, o_input_cap_comp_on;
	logic [3:0] o_cal_pin_on, o_selftest_load_sel, o_skin_load_sel;
	logic [7:0] exp_q[$];
	logic [7:0] ads[4] = '{RX_CTRL_OFS, SWITCH_MATRIX_CTRL_OFS, LOAD_AND_GUARD_CTRL_OFS, 8'h43};
	logic [7:0] mks[4] = '{RX_CTRL_MASK, SM_CTRL_MASK, LG_CTRL_MASK, 8'h00};
	logic [31:0] lfsr = 32'h442F42D1;
	int errors = 0, check_count = 0;

	always #10 i_ref_clk = ~i_ref_clk;

	bsc_switch_ctrl i_bsc_switch_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_tick(i_conv_tick), .i_stim_inphase(i_stim_inphase),
		.i_stim_quad(i_stim_quad), .o_i_demod_clk(o_i_demod_clk), .o_q_demod_clk(o_q_demod_clk),
		.o_inamp_chop(o_inamp_chop), .o_pga_chop(o_pga_chop), .o_electrode_pins_on(o_electrode_pins_on),
		.o_cal_pin_on(o_cal_pin_on), .o_selftest_load_sel(o_selftest_load_sel), .o_skin_load_sel(o_skin_load_sel),
		.o_guard_drive_on(o_guard_drive_on), .o_input_cap_comp_on(o_input_cap_comp_on));

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_ref_clk);
	endtask

	task automatic idle();
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	// Counts the cycles between two toggles, after lining up on a first toggle.
	task automatic period(input bit pga, input int want);
		logic last;
		int n;
		@(negedge i_ref_clk);
		for (int k = 0; k < 3; k++) begin
			last = pga ? o_pga_chop : o_inamp_chop;
			n = 0;
			while ((pga ? o_pga_chop : o_inamp_chop) === last && n < 20) begin
				@(negedge i_ref_clk);
				n++;
			end
			if (n == 20) begin
				errors++;
				wrap_up();
			end
		end
		check(n[7:0], want[7:0]);
	endtask

	// Read data stand in the cycle after the strobe, so they are taken one falling edge later.
	always @(negedge i_ref_clk) begin
		if (rd_seen === 1'b1)
			check(o_rdata, exp_q.pop_front());
		rd_seen = i_rd;
	end

	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		for (int k = 0; k < 4; k++) begin
			rd(ads[k], 8'h00);
			wr(ads[k], 8'hFF);
			rd(ads[k], mks[k]);
		end
		repeat (40) begin
			lfsr = nxt(lfsr);
			sm = lfsr[7:0] & ((lfsr[5] || lfsr[13]) ? 8'hFC : 8'hFF);
			lg = lfsr[15:8];
			i_conv_tick <= lfsr[20];
			wr(RX_CTRL_OFS, {4'h0, lfsr[17:16], 2'b10});
			wr(SWITCH_MATRIX_CTRL_OFS, sm);
			wr(LOAD_AND_GUARD_CTRL_OFS, lg);
			rd(SWITCH_MATRIX_CTRL_OFS, sm & SM_CTRL_MASK);
			i_stim_inphase <= lfsr[24];
			i_stim_quad <= lfsr[25];
			idle();
			@(negedge i_ref_clk);
			check(o_i_demod_clk, lfsr[16] ? lfsr[25] : lfsr[24]);
			check(o_q_demod_clk, lfsr[17] ? lfsr[24] : lfsr[25]);
			check(o_electrode_pins_on, sm[1] && !(sm[0] && sm[2]));
			check(o_cal_pin_on, (sm[1] && sm[0]) ? 4'hF : 4'h0);
			check(o_selftest_load_sel, sm[5] ? 4'h1 << sm[7:6] : 4'h0);
			check(o_skin_load_sel, lg[5] ? 4'h1 << lg[7:6] : 4'h0);
			check(o_guard_drive_on, lg[1]);
			check(o_input_cap_comp_on, lg[0]);
			@(posedge i_ref_clk);
		end
		i_conv_tick <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			wr(RX_CTRL_OFS, {6'h00, 1'b1, s[0]});
			idle();
			period(1'b1, s ? 2 : 4);
			period(1'b0, 1);
			@(posedge i_ref_clk);
		end
		wr(RX_CTRL_OFS, 8'h00);
		repeat (3) idle();
		@(negedge i_ref_clk);
		check(o_inamp_chop, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
